// ==== hlr_regs.v ====
// Purpose: Host link ID, ROM mapping, failed write and control registers.
// Assumes: Register port is synchronous, one access per strobe cycle.
// Notes:   Read data is registered and valid the cycle after reg_rd.
`timescale 1ns/10ps
`include "hlr_defines.vh"

module hlr_regs (
  input  wire        clk,
  input  wire        rstn,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rd_valid,
  input  wire        rom_present,
  input  wire        id_load_valid,
  input  wire [31:0] id_load_upper,
  input  wire [31:0] id_load_lower,
  input  wire        rom_rd_req,
  input  wire [47:0] rom_rd_offset,
  output reg         host_rd_valid,
  output reg  [31:0] host_rd_addr,
  input  wire        pw_fail,
  input  wire [47:0] pw_fail_offset,
  input  wire [15:0] pw_fail_source,
  output wire        link_active_flag,
  output wire        software_reset_flag,
  output wire        fifo_flush,
  output wire [31:0] host_control
);

  // Registers
  reg  [31:0] unique_id_upper;
  reg  [31:0] unique_id_lower;
  reg         lock_upper;
  reg         lock_lower;
  reg  [21:0] rom_image_base_addr;
  reg  [31:0] failed_dest_offset_low;
  reg  [15:0] failed_dest_offset_high;
  reg  [15:0] failed_requester_node;
  reg  [31:0] hc_flags;
  reg  [31:0] next_hc_flags;
  reg  [31:0] next_rdata;

  wire        srst_busy;
  wire        srst_done;
  wire        srst_start;
  wire        wr_upper;
  wire        wr_lower;
  wire        wr_base;
  wire        wr_set;
  wire        wr_clear;
  wire        id_load;

  // True when a serial-bus offset falls in the configuration ROM window
  function in_rom_window;
    input [47:0] ofs;
    begin
      in_rom_window = (ofs >= `HLR_ROM_WIN_LO) && (ofs <= `HLR_ROM_WIN_HI);
    end
  endfunction

  // True when the register port writes the given offset
  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    input       wr;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Write decode
  assign wr_upper = wr_hit(reg_addr, `HLR_OFS_UID_UPPER, reg_wr);
  assign wr_lower = wr_hit(reg_addr, `HLR_OFS_UID_LOWER, reg_wr);
  assign wr_base  = wr_hit(reg_addr, `HLR_OFS_ROM_BASE, reg_wr);
  assign wr_set   = wr_hit(reg_addr, `HLR_OFS_HC_SET, reg_wr) && !srst_busy;
  assign wr_clear = wr_hit(reg_addr, `HLR_OFS_HC_CLEAR, reg_wr) && !srst_busy;

  // Serial ROM load is accepted once, while neither ID is locked
  assign id_load  = rom_present && id_load_valid && !lock_upper && !lock_lower;

  // Soft reset starts when software sets the flag while idle
  assign srst_start = wr_set && reg_wdata[`HLR_HC_SOFT_RESET];

  hlr_soft_reset u_srst (
    .clk   (clk),
    .rstn  (rstn),
    .start (srst_start),
    .busy  (srst_busy),
    .flush (fifo_flush),
    .done  (srst_done)
  );

  // Upper unique ID: hardware reset only, load then lock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unique_id_upper <= `HLR_RST_UID;
      lock_upper      <= 1'b0;
    end else if (id_load) begin
      unique_id_upper <= id_load_upper;
      lock_upper      <= 1'b1;
    end else if (wr_upper && !rom_present && !lock_upper) begin
      unique_id_upper <= reg_wdata;
      lock_upper      <= 1'b1;
    end
  end

  // Lower unique ID: same load and lock as the upper half
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unique_id_lower <= `HLR_RST_UID;
      lock_lower      <= 1'b0;
    end else if (id_load) begin
      unique_id_lower <= id_load_lower;
      lock_lower      <= 1'b1;
    end else if (wr_lower && !rom_present && !lock_lower) begin
      unique_id_lower <= reg_wdata;
      lock_lower      <= 1'b1;
    end
  end

  // ROM image base, low ten bits not stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_image_base_addr <= `HLR_RST_ROM_BASE;
    end else if (srst_busy) begin
      rom_image_base_addr <= `HLR_RST_ROM_BASE;
    end else if (wr_base) begin
      rom_image_base_addr <= reg_wdata[`HLR_ROM_BASE_MSB:`HLR_ROM_BASE_LSB];
    end
  end

  // ROM window reads map to host memory; dropped while link is off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rd_valid <= 1'b0;
      host_rd_addr  <= 32'h00000000;
    end else begin
      host_rd_valid <= 1'b0;
      if (rom_rd_req && link_active_flag && in_rom_window(rom_rd_offset)) begin
        host_rd_valid <= 1'b1;
        host_rd_addr  <= {rom_image_base_addr, {`HLR_ROM_OFS_BITS{1'b0}}}
                         + {22'h000000, rom_rd_offset[`HLR_ROM_OFS_BITS-1:0]};
      end
    end
  end

  // Failed posted write capture, latest failure wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      failed_dest_offset_low  <= `HLR_RST_FAIL;
      failed_dest_offset_high <= 16'h0000;
      failed_requester_node   <= 16'h0000;
    end else if (pw_fail) begin
      failed_dest_offset_low  <= pw_fail_offset[31:0];
      failed_dest_offset_high <= pw_fail_offset[47:32];
      failed_requester_node   <= pw_fail_source;
    end
  end

  // Host control next value: set and clear pair, soft reset restore
  always @* begin
    next_hc_flags = hc_flags;
    if (srst_busy) begin
      next_hc_flags = `HLR_RST_HC;
      next_hc_flags[`HLR_HC_SOFT_RESET] = 1'b1;
    end else begin
      // Flag drops once the sequencer reports done; a new set still wins
      if (srst_done) begin
        next_hc_flags[`HLR_HC_SOFT_RESET] = 1'b0;
      end
      if (wr_set) begin
        next_hc_flags = next_hc_flags | (reg_wdata & `HLR_HC_SET_MASK);
      end
      if (wr_clear) begin
        next_hc_flags = next_hc_flags & ~(reg_wdata & `HLR_HC_CLEAR_MASK);
      end
    end
  end

  // Host control flags
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hc_flags <= `HLR_RST_HC;
    end else begin
      hc_flags <= next_hc_flags;
    end
  end

  assign host_control        = hc_flags;
  assign link_active_flag    = hc_flags[`HLR_HC_LINK_ACTIVE] && !srst_busy;
  assign software_reset_flag = hc_flags[`HLR_HC_SOFT_RESET];

  // Read decode, unmapped offsets return zero
  always @* begin
    next_rdata = 32'h00000000;
    if (reg_addr == `HLR_OFS_UID_UPPER) begin
      next_rdata = unique_id_upper;
    end else if (reg_addr == `HLR_OFS_UID_LOWER) begin
      next_rdata = unique_id_lower;
    end else if (reg_addr == `HLR_OFS_ROM_BASE) begin
      next_rdata = {rom_image_base_addr, {`HLR_ROM_OFS_BITS{1'b0}}};
    end else if (reg_addr == `HLR_OFS_FAIL_LOW) begin
      next_rdata = failed_dest_offset_low;
    end else if (reg_addr == `HLR_OFS_FAIL_HIGH) begin
      next_rdata = {failed_requester_node, failed_dest_offset_high};
    end else if (reg_addr == `HLR_OFS_VENDOR) begin
      next_rdata = `HLR_VENDOR_CODE;
    end else if (reg_addr == `HLR_OFS_HC_SET || reg_addr == `HLR_OFS_HC_CLEAR) begin
      next_rdata = hc_flags;
    end
  end

  // Registered read data
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata    <= 32'h00000000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// ==== hlr_defines.vh ====
// Purpose: Constants for the host link ID and error register bank.
// Assumes: 32-bit register port, byte offsets as printed.
// Notes:   Included by the register bank and the soft reset sequencer.
`ifndef HLR_DEFINES_VH
`define HLR_DEFINES_VH

// Register byte offsets
`define HLR_OFS_UID_UPPER     8'h24
`define HLR_OFS_UID_LOWER     8'h28
`define HLR_OFS_ROM_BASE      8'h34
`define HLR_OFS_FAIL_LOW      8'h38
`define HLR_OFS_FAIL_HIGH     8'h3c
`define HLR_OFS_VENDOR        8'h40
`define HLR_OFS_HC_SET        8'h50
`define HLR_OFS_HC_CLEAR      8'h54

// Reset values
`define HLR_RST_UID           32'h00000000
`define HLR_RST_ROM_BASE      22'h000000
`define HLR_RST_HC            32'h00000000
`define HLR_RST_FAIL          32'h00000000
// Vendor code: no vendor-unique register set
`define HLR_VENDOR_CODE       32'h00000000

// Field positions
`define HLR_ROM_BASE_MSB      31
`define HLR_ROM_BASE_LSB      10
`define HLR_ROM_OFS_BITS      10
`define HLR_FAIL_SRC_MSB      31
`define HLR_FAIL_SRC_LSB      16
`define HLR_FAIL_OFSH_MSB     15
`define HLR_FAIL_OFSH_LSB     0
`define HLR_HC_SOFT_RESET     16
`define HLR_HC_LINK_ACTIVE    17

// Host control writable bits
`define HLR_HC_SET_MASK       32'h404f0000
`define HLR_HC_CLEAR_MASK     32'h40ce0000

// Configuration ROM window on the serial bus
`define HLR_ROM_WIN_LO        48'hfffff0000400
`define HLR_ROM_WIN_HI        48'hfffff00007ff

// Soft reset duration
`define HLR_CLK_PERIOD_NS     5
`define HLR_SRST_TIME_NS      100
`define HLR_SRST_CYCLES       ((`HLR_SRST_TIME_NS + `HLR_CLK_PERIOD_NS - 1) / `HLR_CLK_PERIOD_NS)
`define HLR_SRST_CNT_W        5
// Last count value of the sequence, cycles minus one
`define HLR_SRST_LAST         5'h13

`endif

// ==== hlr_soft_reset.v ====
// Purpose: Soft reset sequencer, holds busy for a fixed number of cycles.
// Assumes: start is a one-cycle pulse; restarts are ignored while busy.
// Notes:   flush pulses once at the start of the sequence.
`timescale 1ns/10ps
`include "hlr_defines.vh"

module hlr_soft_reset (
  input  wire clk,
  input  wire rstn,
  input  wire start,
  output reg  busy,
  output reg  flush,
  output reg  done
);

  localparam [`HLR_SRST_CNT_W-1:0] LAST = `HLR_SRST_LAST;

  reg [`HLR_SRST_CNT_W-1:0] count;

  // Sequence counter and strobes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy  <= 1'b0;
      flush <= 1'b0;
      done  <= 1'b0;
      count <= {`HLR_SRST_CNT_W{1'b0}};
    end else begin
      flush <= 1'b0;
      done  <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy  <= 1'b1;
          flush <= 1'b1;
          count <= {`HLR_SRST_CNT_W{1'b0}};
        end
      end else if (count == LAST) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// ==== hlr_regs_properties.sv ====
// Purpose: Port timing checks for the host link register bank.
// Assumes: One clock, rstn asynchronous active low.
// Notes:   Bound onto hlr_regs from the bench top.
`timescale 1ns/10ps
`include "hlr_defines.vh"
module hlr_props (
  input wire        clk,
  input wire        rstn,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        reg_rd_valid,
  input wire        rom_rd_req,
  input wire [47:0] rom_rd_offset,
  input wire        host_rd_valid,
  input wire [31:0] host_rd_addr,
  input wire        link_active_flag,
  input wire        software_reset_flag,
  input wire        fifo_flush,
  input wire [31:0] host_control
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Decoded request conditions
  wire       in_win = rom_rd_offset >= `HLR_ROM_WIN_LO && rom_rd_offset <= `HLR_ROM_WIN_HI;
  wire       wr_set = reg_wr && reg_addr == `HLR_OFS_HC_SET && !software_reset_flag;
  wire       wr_clr = reg_wr && reg_addr == `HLR_OFS_HC_CLEAR && !software_reset_flag;
  wire [9:0] rom_low = rom_rd_offset[9:0];
  rd_answer_a: assert property (reg_rd |=> reg_rd_valid)
    else $error("read answer missing");
  vendor_zero_a: assert property (reg_rd && reg_addr == `HLR_OFS_VENDOR
    |=> reg_rdata == `HLR_VENDOR_CODE) else $error("vendor code wrong");
  rom_offset_a: assert property (rom_rd_req && link_active_flag && in_win
    |=> host_rd_valid && host_rd_addr[9:0] == $past(rom_low)) else $error("rom map wrong");
  rom_window_a: assert property (rom_rd_req && !in_win |=> !host_rd_valid)
    else $error("out of window read passed");
  link_gate_a: assert property (rom_rd_req && !link_active_flag |=> !host_rd_valid)
    else $error("read passed with link off");
  flush_link_a: assert property (fifo_flush |-> !link_active_flag ##1 host_control == 32'h00010000)
    else $error("link on during soft reset");
  srst_start_a: assert property (wr_set && reg_wdata[16] |-> ##[1:2] fifo_flush)
    else $error("soft reset did not start");
  srst_hold_a: assert property (fifo_flush
    |-> software_reset_flag[*8] ##[1:20] !software_reset_flag) else $error("soft reset length");
  set_flag_a: assert property (wr_set && reg_wdata[17:16] == 2'b10 |=> host_control[17])
    else $error("set write lost");
  clr_flag_a: assert property (wr_clr && reg_wdata[17] |=> !host_control[17])
    else $error("clear write lost");
endmodule

// ==== hlr_regs_tb_top.sv ====
// Purpose: Directed register bank test through the register port.
// Assumes: Inputs change on the falling edge.
// Notes:   Second hard reset covers the serial ROM load path.
`timescale 1ns/10ps
`include "hlr_defines.vh"
module hlr_regs_tb_top;
  reg         clk, rstn, reg_wr, reg_rd, rom_present, id_load_valid, rom_rd_req, pw_fail;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, id_load_upper, id_load_lower;
  reg  [47:0] rom_rd_offset, pw_fail_offset;
  reg  [15:0] pw_fail_source;
  wire [31:0] reg_rdata, host_rd_addr, host_control;
  wire        reg_rd_valid, host_rd_valid, link_active_flag, software_reset_flag, fifo_flush;
  integer     error_cnt = 0, n_compared = 0, cyc = 0, i;
  hlr_regs i_hlr_regs (
    .clk                 (clk),
    .rstn                (rstn),
    .reg_addr            (reg_addr),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .reg_rd_valid        (reg_rd_valid),
    .rom_present         (rom_present),
    .id_load_valid       (id_load_valid),
    .id_load_upper       (id_load_upper),
    .id_load_lower       (id_load_lower),
    .rom_rd_req          (rom_rd_req),
    .rom_rd_offset       (rom_rd_offset),
    .host_rd_valid       (host_rd_valid),
    .host_rd_addr        (host_rd_addr),
    .pw_fail             (pw_fail),
    .pw_fail_offset      (pw_fail_offset),
    .pw_fail_source      (pw_fail_source),
    .link_active_flag    (link_active_flag),
    .software_reset_flag (software_reset_flag),
    .fifo_flush          (fifo_flush),
    .host_control        (host_control)
  );
  // Clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input [8*12:1] nm, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk) reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk) reg_rd = 0;
      chk("rd_valid", 1, reg_rd_valid);
      chk("rdata", e, reg_rdata);
    end
  endtask
  task romq(input [47:0] o, input v, input [31:0] e);
    begin
      @(negedge clk);
      rom_rd_offset = o;
      rom_rd_req = 1;
      @(negedge clk) rom_rd_req = 0;
      chk("host_valid", v, host_rd_valid);
      if (v) chk("host_addr", e, host_rd_addr);
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  // Main sequence
  initial begin
    {rstn, reg_wr, reg_rd, rom_present, id_load_valid, rom_rd_req, pw_fail} = 0;
    {reg_addr, reg_wdata, id_load_upper, id_load_lower} = 0;
    {rom_rd_offset, pw_fail_offset, pw_fail_source} = 0;
    repeat (4) @(negedge clk);
    rstn = 1;
    rd(8'h28, 0);
    rd(8'h34, 0);
    rd(8'h50, 0);
    rd(8'h7c, 0);
    wr(8'h24, 32'h1111_2222);
    wr(8'h24, 32'h3333_4444);
    rd(8'h24, 32'h1111_2222);
    wr(8'h28, 32'h5555_6666);
    wr(8'h28, 0);
    rd(8'h28, 32'h5555_6666);
    wr(8'h34, 32'h1234_57ff);
    rd(8'h34, 32'h1234_5400);
    romq(48'hfffff0000404, 0, 0);
    wr(8'h50, 32'h404e_0000);
    rd(8'h50, 32'h404e_0000);
    chk("link", 1, link_active_flag);
    chk("host_ctrl", 32'h404e_0000, host_control);
    romq(48'hfffff0000404, 1, 32'h1234_5404);
    romq(48'hfffff00007ff, 1, 32'h1234_57ff);
    romq(48'hfffff00003fc, 0, 0);
    romq(48'hfffff0000800, 0, 0);
    wr(8'h54, 32'h0004_0000);
    rd(8'h54, 32'h404a_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, `HLR_VENDOR_CODE);
    pw_fail_offset = 48'habcd_1234_5678;
    pw_fail_source = 16'h0c3f;
    pw_fail = 1;
    @(negedge clk) pw_fail = 0;
    wr(8'h38, 0);
    rd(8'h38, 32'h1234_5678);
    rd(8'h3c, 32'h0c3f_abcd);
    wr(8'h54, 32'h0002_0000);
    romq(48'hfffff0000404, 0, 0);
    wr(8'h50, 32'h0001_0000);
    for (i = 0; i < 3 && !fifo_flush; i = i + 1) @(negedge clk);
    chk("flush", 1, fifo_flush);
    rd(8'h50, 32'h0001_0000);
    wr(8'h50, 32'h0002_0000);
    for (i = 2; i < 40 && software_reset_flag; i = i + 1) @(negedge clk);
    chk("srst_len", 1, i >= `HLR_SRST_CYCLES - 3 && i <= `HLR_SRST_CYCLES + 2);
    rd(8'h50, 0);
    rd(8'h34, 0);
    rd(8'h24, 32'h1111_2222);
    rstn = 0;
    rom_present = 1;
    @(negedge clk) rstn = 1;
    rd(8'h24, 0);
    id_load_upper = 32'ha5a5_0001;
    id_load_lower = 32'h5a5a_0002;
    id_load_valid = 1;
    @(negedge clk) id_load_valid = 0;
    wr(8'h28, 0);
    rd(8'h24, 32'ha5a5_0001);
    rd(8'h28, 32'h5a5a_0002);
    results;
  end
endmodule
bind hlr_regs hlr_props i_hlr_props (
  .clk                 (clk),
  .rstn                (rstn),
  .reg_addr            (reg_addr),
  .reg_wr              (reg_wr),
  .reg_rd              (reg_rd),
  .reg_wdata           (reg_wdata),
  .reg_rdata           (reg_rdata),
  .reg_rd_valid        (reg_rd_valid),
  .rom_rd_req          (rom_rd_req),
  .rom_rd_offset       (rom_rd_offset),
  .host_rd_valid       (host_rd_valid),
  .host_rd_addr        (host_rd_addr),
  .link_active_flag    (link_active_flag),
  .software_reset_flag (software_reset_flag),
  .fifo_flush          (fifo_flush),
  .host_control        (host_control)
);
